// ---- irb_bank_regs.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none


module irb_bank_regs (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Read-only values from the modem datapath
  input wire logic [7:0] i_demod_setting,
  input wire logic [7:0] i_mod_setting,
  input wire logic [7:0] i_consumer_setting,
  // Bank state
  output logic [2:0] o_bank,
  output logic [7:0] o_line_control,
  // Infrared control outputs
  output logic [7:0] o_ir_control_one,
  output logic [7:0] o_ir_control_two,
  output logic [7:0] o_ir_control_three,
  output logic [3:0] o_pulse_width_field,
  output logic [7:0] o_ir_interface_config_one,
  output logic [7:0] o_ir_interface_config_three,
  output logic [7:0] o_ir_interface_config_four,
  // DMA channel use
  output logic [1:0] o_dma_chan_en,
  output logic o_dma_dual
);

  // ****************************************************
  // Decode
  // ****************************************************
  logic [2:0] bank_reg;
  logic [2:0] bank_next;
  logic [6:0] bank_code_reg;
  logic [6:0] bank_code_next;
  logic [7:0] line_ctrl_reg;
  logic [7:0] line_ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rw_hit;
  logic [2:0] rw_idx;
  logic ro_hit;
  logic [1:0] ro_idx;
  logic sel_hit;
  logic [7:0] rw_q [irb_pkg::NUM_RW];
  logic [irb_pkg::NUM_RW-1:0] rw_we;

  // Offsets are the same in every bank; only the bank changes the target
  irb_decode u_decode (
    .i_bank(bank_reg),
    .i_addr(i_addr),
    .o_rw_hit(rw_hit),
    .o_rw_idx(rw_idx),
    .o_ro_hit(ro_hit),
    .o_ro_idx(ro_idx),
    .o_sel_hit(sel_hit)
  );

  // ****************************************************
  // Writable registers
  // ****************************************************
  localparam logic [7:0] RW_MASK [irb_pkg::NUM_RW] = '{
    irb_pkg::MASK_CTRL1, irb_pkg::MASK_CTRL2, irb_pkg::MASK_CTRL3,
    irb_pkg::MASK_PULSE, irb_pkg::MASK_CFG1, irb_pkg::MASK_CFG3,
    irb_pkg::MASK_CFG4, irb_pkg::MASK_DMA};

  // Write enable only on a writable slot, so read-only and reserved
  // offsets have no path to any storage
  always_comb begin
    rw_we = '0;
    if (i_wr && rw_hit) begin
      rw_we[rw_idx] = 1'b1;
    end
  end

  for (genvar g = 0; g < irb_pkg::NUM_RW; g++) begin : g_rw
    irb_byte_reg #(
      .MASK(RW_MASK[g])
    ) u_reg (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_we(rw_we[g]),
      .i_wdata(i_wdata),
      .o_q(rw_q[g])
    );
  end

  // ****************************************************
  // Line control and bank selector
  // ****************************************************
  // Bank code above 7 is kept for readback; only its low three bits
  // steer the decode, since eight banks are all that exist
  always_comb begin
    bank_next = bank_reg;
    bank_code_next = bank_code_reg;
    line_ctrl_next = line_ctrl_reg;
    if (i_wr && sel_hit) begin
      if (i_wdata[irb_pkg::SEL_ENABLE_BIT]) begin
        bank_code_next = i_wdata[6:0];
        bank_next = i_wdata[2:0];
        line_ctrl_next[irb_pkg::SEL_ENABLE_BIT] = 1'b1;
      end else begin
        line_ctrl_next = i_wdata;
        bank_next = irb_pkg::RST_BANK;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bank_reg <= irb_pkg::RST_BANK;
      bank_code_reg <= irb_pkg::RST_BANK_CODE;
      line_ctrl_reg <= irb_pkg::RST_BYTE;
    end else begin
      bank_reg <= bank_next;
      bank_code_reg <= bank_code_next;
      line_ctrl_reg <= line_ctrl_next;
    end
  end

  // ****************************************************
  // Read path
  // ****************************************************
  function automatic logic [7:0] ro_value(input logic [1:0] idx,
                                          input logic [7:0] d,
                                          input logic [7:0] m,
                                          input logic [7:0] c);
    logic [7:0] v;
    v = irb_pkg::ZERO_BYTE;
    case (idx)
      irb_pkg::OFS_DEMOD[1:0]: v = d;
      irb_pkg::OFS_MOD[1:0]: v = m;
      irb_pkg::OFS_CONSUMER[1:0]: v = c;
      default: v = irb_pkg::ZERO_BYTE;
    endcase
    return v;
  endfunction

  // Data stands only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = irb_pkg::ZERO_BYTE;
    if (i_rd) begin
      if (sel_hit) begin
        if (line_ctrl_reg[irb_pkg::SEL_ENABLE_BIT]) begin
          rdata_next = {1'b1, bank_code_reg};
        end else begin
          rdata_next = line_ctrl_reg;
        end
      end else if (ro_hit) begin
        rdata_next = ro_value(ro_idx, i_demod_setting, i_mod_setting,
                              i_consumer_setting);
      end else if (rw_hit) begin
        rdata_next = rw_q[rw_idx];
      end else begin
        rdata_next = irb_pkg::ZERO_BYTE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= irb_pkg::ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // UART banks 0 to 3 carry only the selector and DMA setup here;
  // their UART registers live in the UART block
  assign o_rdata = rdata_reg;
  assign o_bank = bank_reg;
  assign o_line_control = line_ctrl_reg;
  assign o_ir_control_one = rw_q[irb_pkg::IDX_CTRL1];
  assign o_ir_control_two = rw_q[irb_pkg::IDX_CTRL2];
  assign o_ir_control_three = rw_q[irb_pkg::IDX_CTRL3];
  assign o_pulse_width_field = rw_q[irb_pkg::IDX_PULSE][3:0];
  assign o_ir_interface_config_one = rw_q[irb_pkg::IDX_CFG1];
  assign o_ir_interface_config_three = rw_q[irb_pkg::IDX_CFG3];
  assign o_ir_interface_config_four = rw_q[irb_pkg::IDX_CFG4];
  // Either channel alone or both; half-duplex infrared needs just one
  assign o_dma_chan_en = rw_q[irb_pkg::IDX_DMA][1:0];
  assign o_dma_dual = &rw_q[irb_pkg::IDX_DMA][1:0];

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence sel_write_s;
    i_wr && i_addr == irb_pkg::OFS_LINE_BANK &&
    i_wdata[irb_pkg::SEL_ENABLE_BIT];
  endsequence

  sequence sel_read_s;
    i_rd && i_addr == irb_pkg::OFS_LINE_BANK;
  endsequence

  bank_select_a: assert property (
    sel_write_s |=> bank_reg == $past(i_wdata[2:0]))
    else $error("bank not taken from select write");

  select_readback_a: assert property (
    sel_write_s ##1 sel_read_s |=>
      o_rdata == {1'b1, $past(i_wdata[6:0], 2)})
    else $error("selector readback wrong");

  line_ctrl_a: assert property (
    i_wr && i_addr == irb_pkg::OFS_LINE_BANK &&
    !i_wdata[irb_pkg::SEL_ENABLE_BIT] |=>
      line_ctrl_reg == $past(i_wdata) && bank_reg == irb_pkg::RST_BANK)
    else $error("line control write wrong");

  bank_hold_a: assert property (
    !(i_wr && i_addr == irb_pkg::OFS_LINE_BANK) |=> $stable(bank_reg))
    else $error("bank changed without selector write");

  ro_read_a: assert property (
    i_rd && bank_reg == irb_pkg::BANK_CFG &&
    i_addr == irb_pkg::OFS_MOD |=> o_rdata == $past(i_mod_setting))
    else $error("read-only value not returned");

  ro_nowrite_a: assert property (
    i_wr && bank_reg == irb_pkg::BANK_CFG &&
    i_addr <= irb_pkg::OFS_CONSUMER |=> $stable(rw_q[irb_pkg::IDX_CFG1])
      && $stable(rw_q[irb_pkg::IDX_CFG4]) && $stable(line_ctrl_reg))
    else $error("read-only write touched state");

  pulse_width_a: assert property (
    i_wr && bank_reg == irb_pkg::BANK_SIR && i_addr == irb_pkg::OFS_PULSE
    ##1 i_rd && bank_reg == irb_pkg::BANK_SIR &&
    i_addr == irb_pkg::OFS_PULSE |=>
      o_rdata == {4'h0, $past(i_wdata[3:0], 2)})
    else $error("pulse width readback wrong");

  reserved_zero_a: assert property (
    i_rd && bank_reg == irb_pkg::BANK_SIR &&
    i_addr == irb_pkg::OFS_MOD |=> o_rdata == irb_pkg::ZERO_BYTE)
    else $error("reserved offset not zero");

  reserved_quiet_a: assert property (
    i_wr && bank_reg == irb_pkg::BANK_CTRL2 &&
    i_addr == irb_pkg::OFS_CFG3 |=> $stable(rw_q[irb_pkg::IDX_CTRL2]))
    else $error("reserved write had side effect");

  read_one_cycle_a: assert property (
    !i_rd |=> o_rdata == irb_pkg::ZERO_BYTE)
    else $error("read data outside its cycle");

  dma_dual_a: assert property (
    i_wr && bank_reg == irb_pkg::BANK_DMA && i_addr == irb_pkg::OFS_DMA
    |=> o_dma_dual == (&$past(i_wdata[1:0])))
    else $error("dual channel flag wrong");

endmodule

`default_nettype wire

// ---- irb_byte_reg.sv ----
`timescale 1ns/100ps
`default_nettype none

module irb_byte_reg #(
  parameter logic [7:0] MASK = 8'hff
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Write side
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  // Stored value
  output logic [7:0] o_q
);

  logic [7:0] q_reg;
  logic [7:0] q_next;

  // Unimplemented bits never store, so they read back as zero
  always_comb begin
    q_next = q_reg;
    if (i_we) begin
      q_next = i_wdata & MASK;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q_reg <= irb_pkg::RST_BYTE;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule

`default_nettype wire

// ---- irb_decode.sv ----
`timescale 1ns/100ps
`default_nettype none

module irb_decode (
  // Active bank and offset
  input wire logic [2:0] i_bank,
  input wire logic [2:0] i_addr,
  // Writable slot hit
  output logic o_rw_hit,
  output logic [2:0] o_rw_idx,
  // Read-only slot hit
  output logic o_ro_hit,
  output logic [1:0] o_ro_idx,
  // Shared selector offset
  output logic o_sel_hit
);

  // Bank and offset pair to slot, one place for all users
  function automatic logic [3:0] rw_slot(input logic [2:0] b,
                                         input logic [2:0] a);
    logic [3:0] r;
    r = {1'b0, irb_pkg::IDX_CTRL1};
    if (b == irb_pkg::BANK_CTRL1 && a == irb_pkg::OFS_CTRL1)
      r = {1'b1, irb_pkg::IDX_CTRL1};
    else if (b == irb_pkg::BANK_CTRL2 && a == irb_pkg::OFS_CTRL2)
      r = {1'b1, irb_pkg::IDX_CTRL2};
    else if (b == irb_pkg::BANK_SIR && a == irb_pkg::OFS_CTRL3)
      r = {1'b1, irb_pkg::IDX_CTRL3};
    else if (b == irb_pkg::BANK_SIR && a == irb_pkg::OFS_PULSE)
      r = {1'b1, irb_pkg::IDX_PULSE};
    else if (b == irb_pkg::BANK_CFG && a == irb_pkg::OFS_CFG1)
      r = {1'b1, irb_pkg::IDX_CFG1};
    else if (b == irb_pkg::BANK_CFG && a == irb_pkg::OFS_CFG3)
      r = {1'b1, irb_pkg::IDX_CFG3};
    else if (b == irb_pkg::BANK_CFG && a == irb_pkg::OFS_CFG4)
      r = {1'b1, irb_pkg::IDX_CFG4};
    else if (b == irb_pkg::BANK_DMA && a == irb_pkg::OFS_DMA)
      r = {1'b1, irb_pkg::IDX_DMA};
    return r;
  endfunction

  logic [3:0] slot;

  always_comb begin
    slot = rw_slot(i_bank, i_addr);
    o_rw_hit = slot[3];
    o_rw_idx = slot[2:0];
    o_sel_hit = (i_addr == irb_pkg::OFS_LINE_BANK);
    o_ro_hit = (i_bank == irb_pkg::BANK_CFG) &&
               (i_addr <= irb_pkg::OFS_CONSUMER);
    o_ro_idx = i_addr[1:0];
  end

endmodule

`default_nettype wire

// ---- irb_pkg.sv ----
package irb_pkg;

  // ****************************************************
  // Bank and offset layout
  // ****************************************************
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned REGS_PER_BANK = 8;
  localparam logic [2:0] BANK_DMA = 3'h2;
  localparam logic [2:0] BANK_CTRL1 = 3'h4;
  localparam logic [2:0] BANK_CTRL2 = 3'h5;
  localparam logic [2:0] BANK_SIR = 3'h6;
  localparam logic [2:0] BANK_CFG = 3'h7;
  localparam logic [2:0] OFS_DEMOD = 3'h0;
  localparam logic [2:0] OFS_CTRL3 = 3'h0;
  localparam logic [2:0] OFS_MOD = 3'h1;
  localparam logic [2:0] OFS_CTRL1 = 3'h2;
  localparam logic [2:0] OFS_PULSE = 3'h2;
  localparam logic [2:0] OFS_CONSUMER = 3'h2;
  localparam logic [2:0] OFS_LINE_BANK = 3'h3;
  localparam logic [2:0] OFS_CTRL2 = 3'h4;
  localparam logic [2:0] OFS_CFG1 = 3'h4;
  localparam logic [2:0] OFS_DMA = 3'h4;
  localparam logic [2:0] OFS_CFG3 = 3'h6;
  localparam logic [2:0] OFS_CFG4 = 3'h7;

  // ****************************************************
  // Writable register slots
  // ****************************************************
  localparam int unsigned NUM_RW = 8;
  localparam logic [2:0] IDX_CTRL1 = 3'h0;
  localparam logic [2:0] IDX_CTRL2 = 3'h1;
  localparam logic [2:0] IDX_CTRL3 = 3'h2;
  localparam logic [2:0] IDX_PULSE = 3'h3;
  localparam logic [2:0] IDX_CFG1 = 3'h4;
  localparam logic [2:0] IDX_CFG3 = 3'h5;
  localparam logic [2:0] IDX_CFG4 = 3'h6;
  localparam logic [2:0] IDX_DMA = 3'h7;

  // Implemented bits; the rest read as zero
  localparam logic [7:0] MASK_CTRL1 = 8'h0c;
  localparam logic [7:0] MASK_CTRL2 = 8'h13;
  localparam logic [7:0] MASK_CTRL3 = 8'hc0;
  localparam logic [7:0] MASK_PULSE = 8'h0f;
  localparam logic [7:0] MASK_CFG1 = 8'hff;
  localparam logic [7:0] MASK_CFG3 = 8'h77;
  localparam logic [7:0] MASK_CFG4 = 8'hb8;
  localparam logic [7:0] MASK_DMA = 8'h03;

  // ****************************************************
  // Reset values and select fields
  // ****************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_BANK_CODE = 7'h00;
  localparam logic [2:0] RST_BANK = 3'h0;
  localparam int unsigned SEL_ENABLE_BIT = 7;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ****************************************************
  // Stimulus and observed signals
  // ****************************************************
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] dmd = 8'h00;
  logic [7:0] mdl = 8'h00;
  logic [7:0] cns = 8'h00;
  logic [7:0] o_rdata, o_line_control, o_c1, o_c2, o_c3, o_f1, o_f3, o_f4;
  logic [3:0] o_pw;
  logic [2:0] o_bank;
  logic [1:0] o_dma;
  logic o_dual;
  logic rd_seen;
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] rng = 32'h0000b72d;
  logic [7:0] exp_q[$];
  logic [7:0] shadow [8];
  // Writable slots: bank, offset, implemented bits
  localparam logic [13:0] TBL [8] = '{
    {3'h4, 3'h2, 8'h0c}, {3'h5, 3'h4, 8'h13}, {3'h6, 3'h0, 8'hc0},
    {3'h6, 3'h2, 8'h0f}, {3'h7, 3'h4, 8'hff}, {3'h7, 3'h6, 8'h77},
    {3'h7, 3'h7, 8'hb8}, {3'h2, 3'h4, 8'h03}};

  always #5 i_ref_clk = ~i_ref_clk;

  irb_bank_regs dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_demod_setting(dmd), .i_mod_setting(mdl), .i_consumer_setting(cns),
    .o_bank(o_bank), .o_line_control(o_line_control),
    .o_ir_control_one(o_c1), .o_ir_control_two(o_c2),
    .o_ir_control_three(o_c3), .o_pulse_width_field(o_pw),
    .o_ir_interface_config_one(o_f1), .o_ir_interface_config_three(o_f3),
    .o_ir_interface_config_four(o_f4), .o_dma_chan_en(o_dma),
    .o_dma_dual(o_dual)
  );

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  function automatic logic [7:0] out_of(int i);
    case (i)
      0: return o_c1;
      1: return o_c2;
      2: return o_c3;
      3: return {4'h0, o_pw};
      4: return o_f1;
      5: return o_f3;
      6: return o_f4;
      default: return {6'h00, o_dma};
    endcase
  endfunction

  function automatic int find(logic [2:0] b, logic [2:0] o);
    for (int i = 0; i < 8; i++) begin
      if (TBL[i][13:8] == {b, o}) return i;
    end
    return 8;
  endfunction

  task automatic check(logic [7:0] seen, logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Strobes stay up until the next call, so calls may run back to back
  task automatic op(logic w, logic r, logic [2:0] a, logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask

  task automatic rd(logic [2:0] a, logic [7:0] want);
    exp_q.push_back(want);
    op(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic sel(logic [2:0] b);
    op(1'b1, 1'b0, 3'h3, {5'h10, b});
  endtask

  task automatic settle();
    op(1'b0, 1'b0, 3'h0, 8'h00);
    @(negedge i_ref_clk);
  endtask

  task automatic check_outs(logic [2:0] b);
    for (int i = 0; i < 8; i++) check(out_of(i), shadow[i]);
    check({5'h00, o_bank}, {5'h00, b});
    check({7'h00, o_dual}, {7'h00, &shadow[7][1:0]});
  endtask

  // ****************************************************
  // Read data monitor
  // ****************************************************
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_seen <= 1'b0;
    end else begin
      rd_seen <= i_rd;
    end
  end

  // Sampled mid-cycle so the edge's own updates have landed
  always @(negedge i_ref_clk) begin
    if (!i_rst && rd_seen) begin
      if (exp_q.size() > 0) check(o_rdata, exp_q.pop_front());
      else check(o_rdata, 8'hxx);
    end else if (!i_rst) begin
      check(o_rdata, 8'h00);
    end
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    $display("timeout at %0t", $time);
    print_verdict();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    int k;
    logic [7:0] d;
    logic [7:0] want;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    check_outs(3'h0);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      d = rnd();
      sel(TBL[i][13:11]);
      op(1'b1, 1'b0, TBL[i][10:8], d);
      shadow[i] = d & TBL[i][7:0];
      rd(TBL[i][10:8], shadow[i]);
    end
    settle();
    check_outs(3'h2);
    check({7'h00, o_line_control[7]}, 8'h01);
    $display("test writable done");

    @(posedge i_ref_clk);
    dmd <= rnd();
    mdl <= rnd();
    cns <= rnd();
    // Every bank and offset; read-only and reserved places get junk first
    for (int b = 0; b < 8; b++) begin
      sel(b[2:0]);
      for (int o = 0; o < 8; o++) begin
        k = find(b[2:0], o[2:0]);
        if (o == 3) want = {5'h10, b[2:0]};
        else if (k < 8) want = shadow[k];
        else if (b == 7 && o < 3)
          want = (o == 0) ? dmd : (o == 1) ? mdl : cns;
        else want = 8'h00;
        if (o != 3 && k == 8) op(1'b1, 1'b0, o[2:0], rnd());
        rd(o[2:0], want);
      end
    end
    settle();
    check_outs(3'h7);
    $display("test sweep done");

    for (int c = 0; c < 4; c++) begin
      sel(3'h2);
      op(1'b1, 1'b0, 3'h4, c[7:0]);
      shadow[7] = c[7:0];
      settle();
      check({6'h00, o_dma}, c[7:0]);
      check_outs(3'h2);
    end
    $display("test dma done");

    op(1'b1, 1'b0, 3'h3, 8'h5a);
    rd(3'h3, 8'h5a);
    rd(3'h4, 8'h00);
    settle();
    check(o_line_control, 8'h5a);
    check_outs(3'h0);
    op(1'b1, 1'b0, 3'h3, 8'h86);
    rd(3'h3, 8'h86);
    op(1'b1, 1'b0, 3'h2, 8'hff);
    shadow[3] = 8'h0f;
    rd(3'h2, 8'h0f);
    settle();
    check(o_line_control, 8'hda);
    check_outs(3'h6);
    $display("test line control done");

    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    @(negedge i_ref_clk);
    check(o_line_control, 8'h00);
    check_outs(3'h0);
    $display("test second reset done");

    repeat (2) @(negedge i_ref_clk);
    check(8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
